// File: design/cgtw_top.v
// Purpose: Cutter P-gain schedule, tuning profile and thickness window.
// Assumes: Speed and position come from logic on the same clock.
// Notes: APB slave; answers with pready in the access cycle.
`timescale 1ns/1ps
`include "cgtw_defines.vh"

module cgtw_top #(
    parameter GW = 16,
    parameter SW = 24,
    parameter PW = 24
) (
    input wire core_clk_in,
    input wire sys_rst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    input wire [SW-1:0] line_speed_in,
    input wire [PW-1:0] roll_pos_in,
    output reg [GW-1:0] p_gain_out,
    output reg app_profile_out,
    output reg [1:0] thick_level_out,
    output reg thick_win_out
);

    // Settings written by software
    reg sched_sel_q; // Gain schedule select
    reg profile_q; // Tuning profile
    reg [1:0] thick_mode_q; // Thickness tuning level
    reg [GW-1:0] base_gain_q; // Base cutter gain
    reg [GW-1:0] top_gain_q; // Gain at maximum line speed
    reg [SW-1:0] max_speed_q; // Maximum line speed
    reg [PW-1:0] win_open_q; // Window opening position
    reg [PW-1:0] win_close_q; // Window closing position
    reg [PW-1:0] rev_incr_q; // Increments per revolution

    // Working state
    reg [PW-1:0] pos_mod_q; // Position folded into one revolution
    reg in_win_q; // Position is inside the window
    wire [PW-1:0] pos_fold; // Fold of the raw position
    wire open_ok; // At or past the opening position
    wire close_ok; // At or before the closing position
    wire in_win_d; // Window decision for this position
    wire interp_busy; // Interpolator running
    wire interp_done; // Interpolator result ready
    wire [GW-1:0] interp_gain; // Speed-scaled gain
    wire [GW-1:0] gain_d; // Gain to present next

    // APB decode
    wire apb_acc; // Access phase of a transfer
    wire apb_wr; // Write takes effect
    reg addr_hit; // Address is mapped
    reg [31:0] rd_mux; // Read data for the address

    // A write lands only on a mapped address in the access cycle
    assign apb_acc = psel_in & penable_in;
    assign apb_wr = apb_acc & pwrite_in & addr_hit;

    // Address decode and read data
    always @* begin
        addr_hit = 1'b1;
        rd_mux = 32'h00000000;
        case (paddr_in)
            `CGTW_ADDR_CTRL: begin
                rd_mux[`CGTW_CTRL_SCHED_BIT] = sched_sel_q;
                rd_mux[`CGTW_CTRL_PROFILE_BIT] = profile_q;
                rd_mux[`CGTW_CTRL_THICK_MSB:`CGTW_CTRL_THICK_LSB] =
                    thick_mode_q;
            end
            `CGTW_ADDR_BASE_GAIN: rd_mux[GW-1:0] = base_gain_q;
            `CGTW_ADDR_TOP_GAIN: rd_mux[GW-1:0] = top_gain_q;
            `CGTW_ADDR_MAX_SPEED: rd_mux[SW-1:0] = max_speed_q;
            `CGTW_ADDR_WIN_OPEN: rd_mux[PW-1:0] = win_open_q;
            `CGTW_ADDR_WIN_CLOSE: rd_mux[PW-1:0] = win_close_q;
            `CGTW_ADDR_REV_INCR: rd_mux[PW-1:0] = rev_incr_q;
            `CGTW_ADDR_STATUS: begin
                rd_mux[`CGTW_STAT_WIN_BIT] = in_win_q;
                rd_mux[`CGTW_STAT_BUSY_BIT] = interp_busy;
            end
            `CGTW_ADDR_GAIN_NOW: rd_mux[GW-1:0] = p_gain_out;
            default: addr_hit = 1'b0;
        endcase
    end

    // Bus answer: ready in every access cycle, error when unmapped.
    // Ready is raised only by a setup cycle, so it lasts exactly one
    // access cycle; read data is latched from the setup cycle so it
    // is steady for the whole access phase.
    always @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            prdata_out <= 32'h00000000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= psel_in & ~pready_out & ~penable_in;
            pslverr_out <= psel_in & ~penable_in & ~addr_hit;
            if (psel_in && !penable_in && !pwrite_in) begin
                prdata_out <= rd_mux;
            end
        end
    end

    // Setting registers; writes land at the completing edge.
    // Refused values leave the old setting in place, so the loop never
    // sees a level or a speed scale that the rules do not allow.
    always @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            sched_sel_q <= 1'b0;
            profile_q <= 1'b0;
            thick_mode_q <= 2'h0;
            base_gain_q <= `CGTW_RST_GAIN;
            top_gain_q <= `CGTW_RST_GAIN;
            max_speed_q <= `CGTW_RST_MAX_SPEED;
            win_open_q <= `CGTW_RST_WIN_OPEN;
            win_close_q <= `CGTW_RST_WIN_CLOSE;
            rev_incr_q <= `CGTW_RST_REV_INCR;
        end else if (apb_wr && pready_out) begin
            case (paddr_in)
                `CGTW_ADDR_CTRL: begin
                    sched_sel_q <= pwdata_in[`CGTW_CTRL_SCHED_BIT];
                    profile_q <= pwdata_in[`CGTW_CTRL_PROFILE_BIT];
                    // Level 3 is refused; the old level stays
                    if (pwdata_in[`CGTW_CTRL_THICK_MSB:
                                  `CGTW_CTRL_THICK_LSB] <=
                        `CGTW_THICK_MAX) begin
                        thick_mode_q <= pwdata_in[`CGTW_CTRL_THICK_MSB:
                                                  `CGTW_CTRL_THICK_LSB];
                    end
                end
                `CGTW_ADDR_BASE_GAIN: base_gain_q <= pwdata_in[GW-1:0];
                `CGTW_ADDR_TOP_GAIN: top_gain_q <= pwdata_in[GW-1:0];
                `CGTW_ADDR_MAX_SPEED: begin
                    // Out-of-range max speed is refused
                    if (pwdata_in[SW-1:0] >= `CGTW_SPEED_MIN &&
                        pwdata_in[SW-1:0] <= `CGTW_SPEED_MAX &&
                        pwdata_in[31:SW] == 0) begin
                        max_speed_q <= pwdata_in[SW-1:0];
                    end
                end
                `CGTW_ADDR_WIN_OPEN: win_open_q <= pwdata_in[PW-1:0];
                `CGTW_ADDR_WIN_CLOSE: win_close_q <= pwdata_in[PW-1:0];
                `CGTW_ADDR_REV_INCR: begin
                    // Zero increments per revolution would break the fold
                    if (pwdata_in[PW-1:0] != 0) begin
                        rev_incr_q <= pwdata_in[PW-1:0];
                    end
                end
                default: begin
                    // Read-only or unmapped: nothing stored
                end
            endcase
        end
    end

    // Speed-proportional gain, recomputed continuously.
    // The interpolator restarts as soon as it finishes while select is 1;
    // a result lands at least every eighteen cycles, far faster than a line
    // speed change, so the loop never holds a stale gain for long.
    cgtw_gain_interp #(
        .GW(GW),
        .SW(SW)
    ) u_interp (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(sched_sel_q),
        .speed_in(line_speed_in),
        .max_speed_in(max_speed_q),
        .base_gain_in(base_gain_q),
        .top_gain_in(top_gain_q),
        .busy_out(interp_busy),
        .done_out(interp_done),
        .gain_out(interp_gain)
    );

    // Constant gain in select 0, scaled gain in select 1
    // Switching select back to 0 takes the base gain on the next edge
    assign gain_d = sched_sel_q ? interp_gain : base_gain_q;

    // Position relative to the cut pulse, folded into one revolution.
    // Only one subtraction is made, so the roll position must stay
    // below two revolutions; the drive wraps it at the cut pulse.
    assign pos_fold = (roll_pos_in >= rev_incr_q) ?
                      roll_pos_in - rev_incr_q : roll_pos_in;
    assign open_ok = pos_mod_q >= win_open_q;
    assign close_ok = pos_mod_q <= win_close_q;
    // A window with open above close spans the cut pulse
    assign in_win_d = (win_open_q <= win_close_q) ?
                      (open_ok & close_ok) :
                      (open_ok | close_ok);

    // Outputs to the loop.
    // Window flag and level use the same decision, so the level can
    // never show outside the window, not even for one cycle.
    always @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            pos_mod_q <= {PW{1'b0}};
            in_win_q <= 1'b0;
            p_gain_out <= `CGTW_RST_GAIN;
            app_profile_out <= 1'b0;
            thick_level_out <= 2'h0;
            thick_win_out <= 1'b0;
        end else begin
            pos_mod_q <= pos_fold;
            in_win_q <= in_win_d;
            thick_win_out <= in_win_d;
            app_profile_out <= profile_q;
            // Thickness level only while inside the window
            thick_level_out <= in_win_d ? thick_mode_q : 2'h0;
            // Scaled gain updates on each finished computation
            if (!sched_sel_q) begin
                p_gain_out <= gain_d;
            end else if (interp_done) begin
                p_gain_out <= gain_d;
            end
        end
    end

endmodule

// File: design/cgtw_defines.vh
// Purpose: Constants for the cutter gain schedule and thickness window.
// Assumes: APB slave, 32-bit data, one word per register.
// Notes: Register map, field positions, limits and fraction scaling.
`ifndef CGTW_DEFINES_VH
`define CGTW_DEFINES_VH

// Register byte addresses
`define CGTW_ADDR_CTRL 8'h00
`define CGTW_ADDR_BASE_GAIN 8'h04
`define CGTW_ADDR_TOP_GAIN 8'h08
`define CGTW_ADDR_MAX_SPEED 8'h0C
`define CGTW_ADDR_WIN_OPEN 8'h10
`define CGTW_ADDR_WIN_CLOSE 8'h14
`define CGTW_ADDR_REV_INCR 8'h18
`define CGTW_ADDR_STATUS 8'h1C
`define CGTW_ADDR_GAIN_NOW 8'h20

// Control register field positions
`define CGTW_CTRL_SCHED_BIT 0
`define CGTW_CTRL_PROFILE_BIT 1
`define CGTW_CTRL_THICK_LSB 2
`define CGTW_CTRL_THICK_MSB 3

// Status register field positions
`define CGTW_STAT_WIN_BIT 0
`define CGTW_STAT_BUSY_BIT 1

// Limits and reset values
`define CGTW_THICK_MAX 2'h2
`define CGTW_SPEED_MIN 24'h000001
`define CGTW_SPEED_MAX 24'h98967F
`define CGTW_RST_GAIN 16'h0100
`define CGTW_RST_MAX_SPEED 24'h98967F
`define CGTW_RST_REV_INCR 24'h004E20
`define CGTW_RST_WIN_OPEN 24'h000000
`define CGTW_RST_WIN_CLOSE 24'h000000

// Fraction scaling: unity speed ratio is 2^16
`define CGTW_FRAC_BITS 16
`define CGTW_FRAC_ONE 17'h10000

`endif

// File: design/cgtw_gain_interp.v
// Purpose: Speed-proportional gain between base and top gain.
// Assumes: Operands stay steady while busy; max speed is non-zero.
// Notes: Ratio by 16-step restoring division, then one multiply.
`timescale 1ns/1ps
`include "cgtw_defines.vh"

module cgtw_gain_interp #(
    parameter GW = 16,
    parameter SW = 24
) (
    input wire core_clk_in,
    input wire sys_rst_in,
    input wire start_in,
    input wire [SW-1:0] speed_in,
    input wire [SW-1:0] max_speed_in,
    input wire [GW-1:0] base_gain_in,
    input wire [GW-1:0] top_gain_in,
    output reg busy_out,
    output reg done_out,
    output reg [GW-1:0] gain_out
);

    localparam FB = `CGTW_FRAC_BITS;

    reg [SW:0] rem_q; // Division remainder
    reg [FB:0] frac_q; // Speed ratio, 2^16 means full speed
    reg [4:0] step_q; // Division steps left
    reg fin_q; // Multiply stage pending
    wire [SW:0] rem_sh; // Remainder shifted by one
    wire rem_ge; // Shifted remainder reaches divisor
    wire signed [GW+1:0] diff_s; // Top minus base, signed
    wire signed [GW+FB+2:0] prod_s; // Difference times ratio
    wire signed [GW+2:0] sum_s; // Base plus scaled difference

    assign rem_sh = {rem_q[SW-1:0], 1'b0};
    assign rem_ge = rem_sh >= {1'b0, max_speed_in};
    assign diff_s = $signed({2'b00, top_gain_in}) -
                    $signed({2'b00, base_gain_in});
    assign prod_s = diff_s * $signed({1'b0, frac_q});
    assign sum_s = $signed({3'b000, base_gain_in}) +
                   $signed(prod_s[GW+FB+2:FB]);

    // Divide speed by max speed, then scale the gain span
    always @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            rem_q <= {(SW+1){1'b0}};
            frac_q <= {(FB+1){1'b0}};
            step_q <= 5'h00;
            fin_q <= 1'b0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            gain_out <= {GW{1'b0}};
        end else begin
            done_out <= 1'b0;
            if (start_in && !busy_out) begin
                busy_out <= 1'b1;
                if (speed_in >= max_speed_in) begin
                    // Full speed or above clamps to the top gain
                    frac_q <= `CGTW_FRAC_ONE;
                    step_q <= 5'h00;
                    fin_q <= 1'b1;
                end else begin
                    rem_q <= {1'b0, speed_in};
                    frac_q <= {(FB+1){1'b0}};
                    step_q <= 5'h10;
                    fin_q <= 1'b0;
                end
            end else if (busy_out && step_q != 5'h00) begin
                // One quotient bit per cycle
                if (rem_ge) begin
                    rem_q <= rem_sh - {1'b0, max_speed_in};
                end else begin
                    rem_q <= rem_sh;
                end
                frac_q <= {frac_q[FB-1:0], rem_ge};
                step_q <= step_q - 5'h01;
                fin_q <= (step_q == 5'h01);
            end else if (busy_out && fin_q) begin
                // Result lies between base and top, so it fits
                gain_out <= sum_s[GW-1:0];
                fin_q <= 1'b0;
                busy_out <= 1'b0;
                done_out <= 1'b1;
            end
        end
    end

endmodule

// File: sim/cgtw_assertions.sv
// Purpose: Port checks for the gain schedule and thickness window.
// Assumes: One clock, sync active-high reset.
// Notes: Sees only top ports; bound below.
`timescale 1ns/1ps
module cgtw_assertions #(parameter GW = 16, parameter SW = 24,
    parameter PW = 24) (
    input wire core_clk_in,
    input wire sys_rst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [31:0] prdata_out,
    input wire pready_out,
    input wire pslverr_out,
    input wire [GW-1:0] p_gain_out,
    input wire app_profile_out,
    input wire [1:0] thick_level_out,
    input wire thick_win_out
);
    // All checks on the core clock, quiet in reset
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    a_setup_gets_ready: assert property (psel_in && !penable_in |=>
        pready_out) else $error("No ready after setup");
    a_ready_one_cycle: assert property (pready_out |=> !pready_out)
        else $error("Ready held too long");
    a_ready_after_setup: assert property (pready_out |->
        $past(psel_in && !penable_in)) else $error("Ready without setup");
    a_err_read_zero: assert property (pslverr_out && !pwrite_in |->
        pready_out && prdata_out == 32'h0) else $error("Bad error read");
    a_thick_outside_zero: assert property (!thick_win_out |->
        thick_level_out == 2'h0) else $error("Level outside window");
    a_thick_code_legal: assert property (thick_level_out != 2'h3)
        else $error("Illegal thickness level");
    a_reset_state: assert property ($fell(sys_rst_in) |->
        p_gain_out == 16'h0100 && !app_profile_out && !thick_win_out)
        else $error("Bad state after reset");
    a_profile_by_write: assert property ($changed(app_profile_out) |->
        $past(pready_out && pwrite_in) || $past(pready_out && pwrite_in, 2))
        else $error("Profile moved without write");
endmodule
bind cgtw_top cgtw_assertions #(.GW(GW), .SW(SW), .PW(PW)) chk_u (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .p_gain_out(p_gain_out),
    .app_profile_out(app_profile_out), .thick_level_out(thick_level_out),
    .thick_win_out(thick_win_out));

// File: sim/cgtw_roll_model.sv
// Purpose: Cutting roll encoder position and line speed source.
// Assumes: Position counts from the cut pulse, wraps at span.
// Notes: Load jumps the roll; run steps one increment a cycle.
`timescale 1ns/1ps
module cgtw_roll_model #(parameter PW = 24, parameter SW = 24) (
    input wire core_clk_in,
    input wire load_in,
    input wire [PW-1:0] pos_in,
    input wire run_in,
    input wire [SW-1:0] speed_in,
    input wire [PW-1:0] span_in,
    output reg [PW-1:0] roll_pos_out,
    output reg [SW-1:0] line_speed_out
);
    // Roll at the cut pulse until moved
    initial roll_pos_out = '0;
    initial line_speed_out = '0;
    // Position zero is the cut pulse; wrap after span increments
    always @(posedge core_clk_in) begin
        line_speed_out <= speed_in;
        if (load_in) begin
            roll_pos_out <= pos_in;
        end else if (run_in) begin
            if (roll_pos_out + 1'b1 >= span_in) roll_pos_out <= '0;
            else roll_pos_out <= roll_pos_out + 1'b1;
        end
    end
endmodule

// File: sim/cgtw_top_tb_top.sv
// Purpose: Self-checking bench for the gain schedule block.
// Assumes: APB answers in the access cycle.
// Notes: Roll model feeds position and speed.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); fail_count++; end end
module cgtw_top_tb_top;
    logic core_clk_in = 0, sys_rst_in = 1, psel_in = 0, penable_in = 0;
    logic pwrite_in = 0, pready_out, pslverr_out, app_profile_out;
    logic thick_win_out, load = 0, run = 0, er;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic [23:0] line_speed_in, roll_pos_in, spd = 0, pos = 0, span = 200;
    logic [15:0] p_gain_out;
    logic [1:0] thick_level_out;
    int fail_count = 0, checks = 0;
    // Clock at 10 MHz
    initial forever #50 core_clk_in = ~core_clk_in;
    cgtw_top dut_u (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .line_speed_in(line_speed_in), .roll_pos_in(roll_pos_in),
        .p_gain_out(p_gain_out), .app_profile_out(app_profile_out),
        .thick_level_out(thick_level_out), .thick_win_out(thick_win_out));
    cgtw_roll_model roll_u (.core_clk_in(core_clk_in), .load_in(load),
        .pos_in(pos), .run_in(run), .speed_in(spd), .span_in(span),
        .roll_pos_out(roll_pos_in), .line_speed_out(line_speed_in));
    task stop_test;
        if (fail_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // One APB transfer, held until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk_in);
        psel_in <= 1; penable_in <= 0; pwrite_in <= wr;
        paddr_in <= a; pwdata_in <= wd;
        @(posedge core_clk_in);
        penable_in <= 1;
        do begin @(posedge core_clk_in); n++; end
        while (pready_out !== 1'b1 && n < 20);
        if (pready_out !== 1'b1) begin fail_count++; stop_test; end
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 0; penable_in <= 0;
    endtask
    // Wait a bounded time for the gain to settle on a value
    task wait_gain(input logic [15:0] e);
        int n;
        n = 0;
        while (p_gain_out !== e && n < 60) begin
            @(posedge core_clk_in); n++;
        end
        `CHK("gain", e, p_gain_out)
        if (n >= 60) stop_test;
    endtask
    // Jump the roll and check window flag and level
    task chkpos(input logic [23:0] p, input logic w, input logic [1:0] l);
        @(posedge core_clk_in); load <= 1; pos <= p;
        @(posedge core_clk_in); load <= 0;
        repeat (3) @(posedge core_clk_in);
        `CHK("win", w, thick_win_out)
        `CHK("lvl", l, thick_level_out)
    endtask
    // Reset values, unmapped address, refused max speed
    task t_regs;
        logic [31:0] e [7];
        int i;
        e = '{32'h0, 32'h100, 32'h100, 32'h98967F, 32'h0, 32'h0, 32'h4E20};
        for (i = 0; i < 7; i++) begin
            apb(0, 8'(i * 4), 32'h0);
            `CHK("reg", e[i], rd)
        end
        apb(0, 8'h24, 32'h0);
        `CHK("err", 1'b1, er)
        `CHK("rdz", 32'h0, rd)
        apb(1, 8'h0C, 32'h0);
        apb(1, 8'h0C, 32'h989680);
        apb(0, 8'h0C, 32'h0);
        `CHK("max", 32'h98967F, rd)
    endtask
    // Constant gain, then speed-proportional gain
    task t_gain;
        apb(1, 8'h04, 32'h200);
        apb(1, 8'h08, 32'h700);
        spd <= 24'd5000;
        repeat (38) @(posedge core_clk_in);
        `CHK("gain", 16'h0200, p_gain_out)
        apb(1, 8'h0C, 32'd1000);
        spd <= 24'd500;
        apb(1, 8'h00, 32'h1);
        wait_gain(16'h0480);
        apb(0, 8'h20, 32'h0);
        `CHK("gainrd", 32'h480, rd)
        spd <= 24'd0;
        wait_gain(16'h0200);
        spd <= 24'd2000;
        wait_gain(16'h0700);
        apb(1, 8'h00, 32'h0);
        wait_gain(16'h0200);
    endtask
    // Both tuning profiles
    task t_profile;
        apb(1, 8'h00, 32'h2);
        repeat (2) @(posedge core_clk_in);
        `CHK("prof", 1'b1, app_profile_out)
        apb(1, 8'h00, 32'h0);
        repeat (2) @(posedge core_clk_in);
        `CHK("prof", 1'b0, app_profile_out)
    endtask
    // Window bounds, wrap, thickness codes and a running roll
    task t_window;
        int i, c;
        apb(1, 8'h18, 32'd100);
        apb(1, 8'h10, 32'd90);
        apb(1, 8'h14, 32'd10);
        for (i = 0; i < 3; i++) begin
            apb(1, 8'h00, 32'(i << 2));
            chkpos(24'd95, 1'b1, 2'(i));
        end
        apb(1, 8'h00, 32'hC);
        apb(0, 8'h00, 32'h0);
        `CHK("ctrl", 32'h8, rd)
        chkpos(24'd0, 1'b1, 2'h2);
        chkpos(24'd10, 1'b1, 2'h2);
        apb(0, 8'h1C, 32'h0);
        `CHK("stat", 32'h1, rd)
        chkpos(24'd11, 1'b0, 2'h0);
        chkpos(24'd89, 1'b0, 2'h0);
        chkpos(24'd195, 1'b1, 2'h2);
        chkpos(24'd150, 1'b0, 2'h0);
        run <= 1;
        c = 0;
        repeat (5) @(posedge core_clk_in);
        repeat (200) begin @(posedge core_clk_in); c += thick_win_out; end
        run <= 0;
        `CHK("wincount", 42, c)
        apb(1, 8'h10, 32'd20);
        apb(1, 8'h14, 32'd30);
        chkpos(24'd25, 1'b1, 2'h2);
        chkpos(24'd19, 1'b0, 2'h0);
    endtask
    // Reset in mid-run brings gain and settings back
    task t_reset;
        @(posedge core_clk_in);
        sys_rst_in <= 1;
        repeat (2) @(posedge core_clk_in);
        sys_rst_in <= 0;
        @(posedge core_clk_in);
        `CHK("rstgain", 16'h0100, p_gain_out)
        apb(0, 8'h04, 32'h0);
        `CHK("rstbase", 32'h100, rd)
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge core_clk_in);
        sys_rst_in <= 0;
        t_regs;
        t_gain;
        t_profile;
        t_window;
        t_reset;
        stop_test;
    end
    // Hang guard
    initial begin
        #10000000;
        fail_count++;
        stop_test;
    end
endmodule
